// File: hw/iop_defs.vh
// Constants for the I/O ports and miscellaneous control block.
// Contract
// - Direction bit clear makes pin input; set drives pin from data latch.
// - Data register writes always update the latch, even for input pins.
// - Data read returns latch for outputs, synchronized pin level for inputs.
// - Ports A and B data and direction reset to all zeros.
// - Port C has bits 2..0 only; upper bits unwritable, reset with upper bits set.
// - Registers decode at consecutive addresses: A data, A dir, B, then C.
// - Misc control resets to F0; reserved upper four bits always read one.
// - Low-voltage-detect disable bit set by software, cleared only by reset.
// - Crystal rate select bit set by software, cleared only by reset.
// - USB route bit set puts USB transmit enable on port C pin 2.
// - Clock-out bit freely written; when set, port A pin 0 outputs CPU clock.
// - Port B pins are analog inputs; channel select 0..7 picks pin 0..7.
// - Port B pins 4..7 are external interrupt lines five to eight, each enabled.
// - Port A pins 1,2 are open-drain only, carry I2C data and clock when enabled.
// - An enabled peripheral function overrides pin direction and data settings.
// - Output pins never raise external interrupt requests.
// - Enabled pins sharing one interrupt vector are ORed into one request.
`ifndef IOP_DEFS_VH
`define IOP_DEFS_VH
`define IOP_ADDR_W 4
`define IOP_PA_DATA 4'h0
`define IOP_PA_DIR 4'h1
`define IOP_PB_DATA 4'h2
`define IOP_PB_DIR 4'h3
`define IOP_PC_DATA 4'h4
`define IOP_PC_DIR 4'h5
`define IOP_IRQ_STATUS 4'h6
`define IOP_IRQ_CLEAR 4'h7
`define IOP_IRQ_ENABLE 4'h8
`define IOP_MISC 4'h9
`define IOP_EXT_CFG 4'hA
`define IOP_AB_RESET 8'h00
`define IOP_PC_MASK 8'h07
`define IOP_PC_RESET 8'hF8
`define IOP_MISC_RESET 8'hF0
`define IOP_MISC_RSVD 8'hF0
`define IOP_MISC_DETOFF 3
`define IOP_MISC_XTAL 2
`define IOP_MISC_USB 1
`define IOP_MISC_CLKOUT 0
`define IOP_PA_CLKOUT 0
`define IOP_PA_SDA 1
`define IOP_PA_SCL 2
`define IOP_PC_RX 0
`define IOP_PC_TX 1
`define IOP_PC_USB 2
`endif

// File: hw/iop_ports.v
// I/O ports A, B, C with miscellaneous control and external interrupt lines.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ns
`include "iop_defs.vh"
module iop_ports (
    input wire clk,
    input wire srst,
    input wire [3:0] addr,
    input wire [7:0] wrData,
    input wire wrStb,
    input wire rdStb,
    output reg [7:0] rdData,
    input wire [7:0] portAIn,
    output wire [7:0] portAOut,
    output wire [7:0] portAOe_n,
    input wire [7:0] portBIn,
    output wire [7:0] portBOut,
    output wire [7:0] portBOe_n,
    input wire [2:0] portCIn,
    output wire [2:0] portCOut,
    output wire [2:0] portCOe_n,
    input wire i2cEnable,
    input wire sdaOut,
    input wire sclOut,
    output wire sdaIn,
    output wire sclIn,
    input wire serialEnable,
    input wire serialTx,
    output wire serialRx,
    input wire usbTxActive,
    input wire [2:0] analogChannelSelect,
    output wire [7:0] analogInputSelect,
    output wire [3:0] extIrqLines,
    output wire lowVoltageDetectDisable,
    output wire crystalRateSelect,
    output wire irq
);
    // Register bank, synchroniser stages and the divided clock image.
    reg [7:0] paData_reg;
    reg [7:0] paDir_reg;
    reg [7:0] pbData_reg;
    reg [7:0] pbDir_reg;
    reg [7:0] pcData_reg;
    reg [7:0] pcDir_reg;
    reg [7:0] misc_reg;
    reg [3:0] extCfg_reg;
    reg [3:0] irqStatus_reg;
    reg [3:0] irqEnable_reg;
    reg [3:0] extPrev_reg;
    reg [7:0] aSync1_reg;
    reg [7:0] aSync2_reg;
    reg [7:0] bSync1_reg;
    reg [7:0] bSync2_reg;
    reg [2:0] cSync1_reg;
    reg [2:0] cSync2_reg;
    reg cpuClkPhase_reg;
    reg [7:0] rdData_next;
    wire [7:0] paRead;
    wire [7:0] pbRead;
    wire [2:0] pcRead;
    wire [3:0] extNow;
    wire [3:0] extRise;
    wire [7:0] aOutEff;
    wire [7:0] aDirEff;
    wire [2:0] cOutEff;
    wire [2:0] cDirEff;
    // Per-pin alternate function paths.
    wire pa0Out;
    wire pa0Dir;
    wire pa1PullLow;
    wire pa2PullLow;
    wire pc0Dir;
    wire pc1Out;
    wire pc1Dir;
    wire pc2Out;
    wire pc2Dir;

    // Port A synchroniser. Pins move with no regard for the core clock, so the
    // first flop may go metastable; nothing but the second flop reads it.
    always @(posedge clk) begin
        if (srst) begin
            aSync1_reg <= 8'h00;
            aSync2_reg <= 8'h00;
        end else begin
            aSync1_reg <= portAIn;
            aSync2_reg <= aSync1_reg;
        end
    end

    // Port B synchroniser; it also feeds the external interrupt lines.
    always @(posedge clk) begin
        if (srst) begin
            bSync1_reg <= 8'h00;
            bSync2_reg <= 8'h00;
        end else begin
            bSync1_reg <= portBIn;
            bSync2_reg <= bSync1_reg;
        end
    end

    // Port C synchroniser; the serial receive line comes from its second stage.
    always @(posedge clk) begin
        if (srst) begin
            cSync1_reg <= 3'h0;
            cSync2_reg <= 3'h0;
        end else begin
            cSync1_reg <= portCIn;
            cSync2_reg <= cSync1_reg;
        end
    end

    // The CPU clock image toggles every cycle, so the pin shows half the core rate.
    // A divided image keeps the pin inside the one clock domain of the block.
    always @(posedge clk) begin
        if (srst) begin
            cpuClkPhase_reg <= 1'b0;
        end else begin
            cpuClkPhase_reg <= ~cpuClkPhase_reg;
        end
    end

    // Port A data latch; a write lands even while the pin is an input, so the
    // level is ready before software turns the pin around.
    always @(posedge clk) begin
        if (srst) begin
            paData_reg <= `IOP_AB_RESET;
        end else if (wrStb && addr == `IOP_PA_DATA) begin
            paData_reg <= wrData;
        end
    end

    // Port A direction; a set bit makes the pin drive.
    always @(posedge clk) begin
        if (srst) begin
            paDir_reg <= `IOP_AB_RESET;
        end else if (wrStb && addr == `IOP_PA_DIR) begin
            paDir_reg <= wrData;
        end
    end

    // Port B data latch, written whatever the pin direction.
    always @(posedge clk) begin
        if (srst) begin
            pbData_reg <= `IOP_AB_RESET;
        end else if (wrStb && addr == `IOP_PB_DATA) begin
            pbData_reg <= wrData;
        end
    end

    // Port B direction; every pin starts as an input after reset.
    always @(posedge clk) begin
        if (srst) begin
            pbDir_reg <= `IOP_AB_RESET;
        end else if (wrStb && addr == `IOP_PB_DIR) begin
            pbDir_reg <= wrData;
        end
    end

    // Port C data latch. Bits 7..3 have no pins behind them; they are kept set
    // and ignore whatever software writes there.
    always @(posedge clk) begin
        if (srst) begin
            pcData_reg <= `IOP_PC_RESET;
        end else if (wrStb && addr == `IOP_PC_DATA) begin
            pcData_reg <= (wrData & `IOP_PC_MASK) | `IOP_PC_RESET;
        end
    end

    // Port C direction, with the same fixed upper bits as the latch.
    always @(posedge clk) begin
        if (srst) begin
            pcDir_reg <= `IOP_PC_RESET;
        end else if (wrStb && addr == `IOP_PC_DIR) begin
            pcDir_reg <= (wrData & `IOP_PC_MASK) | `IOP_PC_RESET;
        end
    end

    // Interrupt enable register; it masks the output only, not the status.
    always @(posedge clk) begin
        if (srst) begin
            irqEnable_reg <= 4'h0;
        end else if (wrStb && addr == `IOP_IRQ_ENABLE) begin
            irqEnable_reg <= wrData[3:0];
        end
    end

    // External line enables; bit 0 gates line five and bit 3 line eight.
    always @(posedge clk) begin
        if (srst) begin
            extCfg_reg <= 4'h0;
        end else if (wrStb && addr == `IOP_EXT_CFG) begin
            extCfg_reg <= wrData[3:0];
        end
    end

    // Misc control. The detector-off and crystal-rate bits only go up under
    // software, so a later write of zero cannot undo them; only reset clears them.
    always @(posedge clk) begin
        if (srst) begin
            misc_reg <= `IOP_MISC_RESET;
        end else if (wrStb && addr == `IOP_MISC) begin
            misc_reg[`IOP_MISC_DETOFF] <= misc_reg[`IOP_MISC_DETOFF]
                | wrData[`IOP_MISC_DETOFF];
            misc_reg[`IOP_MISC_XTAL] <= misc_reg[`IOP_MISC_XTAL]
                | wrData[`IOP_MISC_XTAL];
            misc_reg[`IOP_MISC_USB] <= wrData[`IOP_MISC_USB];
            misc_reg[`IOP_MISC_CLKOUT] <= wrData[`IOP_MISC_CLKOUT];
        end
    end

    // Pin A0 shows the latch or, when selected, the CPU clock image; the clock
    // function forces the pin to drive so that the image reaches the board.
    assign pa0Out = misc_reg[`IOP_MISC_CLKOUT] ? cpuClkPhase_reg
        : paData_reg[`IOP_PA_CLKOUT];
    assign pa0Dir = paDir_reg[`IOP_PA_CLKOUT] | misc_reg[`IOP_MISC_CLKOUT];

    // Open drain: pins A1 and A2 pull low only when their level is zero and are
    // otherwise released. The I2C controller takes them over when enabled.
    assign pa1PullLow = i2cEnable ? ~sdaOut
        : paDir_reg[`IOP_PA_SDA] & ~paData_reg[`IOP_PA_SDA];
    assign pa2PullLow = i2cEnable ? ~sclOut
        : paDir_reg[`IOP_PA_SCL] & ~paData_reg[`IOP_PA_SCL];

    // Effective port A drive and direction; pins 1 and 2 never drive high.
    assign aOutEff = {paData_reg[7:3], 2'h0, pa0Out};
    assign aDirEff = {paDir_reg[7:1], pa0Dir};

    // Pin drive values and enables for port A.
    assign portAOut = aOutEff;
    assign portAOe_n = {~aDirEff[7:3], ~pa2PullLow, ~pa1PullLow, ~aDirEff[0]};

    // The I2C controller hears the synchronised levels of its two lines.
    assign sdaIn = aSync2_reg[`IOP_PA_SDA];
    assign sclIn = aSync2_reg[`IOP_PA_SCL];

    // Port B has no digital alternate drive; latch and direction go straight out.
    assign portBOut = pbData_reg;
    assign portBOe_n = ~pbDir_reg;

    // One-hot analog input select; the converter itself sits outside this block.
    assign analogInputSelect = 8'h01 << analogChannelSelect;

    // Pin C0 is the serial receive line; while the serial interface runs the
    // pin is held as an input so that the far end can drive it.
    assign pc0Dir = pcDir_reg[`IOP_PC_RX] & ~serialEnable;

    // Pin C1 carries the serial transmit line and is forced to drive meanwhile.
    assign pc1Out = serialEnable ? serialTx : pcData_reg[`IOP_PC_TX];
    assign pc1Dir = pcDir_reg[`IOP_PC_TX] | serialEnable;

    // Pin C2 shows the USB transmit enable when routed, high while sending.
    assign pc2Out = misc_reg[`IOP_MISC_USB] ? usbTxActive
        : pcData_reg[`IOP_PC_USB];
    assign pc2Dir = pcDir_reg[`IOP_PC_USB] | misc_reg[`IOP_MISC_USB];

    // Effective port C drive and direction, and the received serial level.
    assign cOutEff = {pc2Out, pc1Out, pcData_reg[`IOP_PC_RX]};
    assign cDirEff = {pc2Dir, pc1Dir, pc0Dir};
    assign portCOut = cOutEff;
    assign portCOe_n = ~cDirEff;
    assign serialRx = cSync2_reg[`IOP_PC_RX];

    // Read-back mux: latch for output pins, synchronised level for inputs.
    // A pin level therefore shows in a read two cycles after it changes.
    assign paRead = (paData_reg & aDirEff) | (aSync2_reg & ~aDirEff);
    assign pbRead = (pbData_reg & pbDir_reg) | (bSync2_reg & ~pbDir_reg);
    assign pcRead = (pcData_reg[2:0] & cDirEff) | (cSync2_reg & ~cDirEff);

    // External lines are masked by enable and by output mode of the pin.
    // Masking at the source keeps a driven pin from ever posting an event.
    assign extNow = bSync2_reg[7:4] & extCfg_reg & ~pbDir_reg[7:4];
    assign extIrqLines = extNow;
    assign extRise = extNow & ~extPrev_reg;

    // Previous level of each interrupt line, for rising-edge detection. It resets
    // low like the lines themselves, so no false edge follows reset.
    always @(posedge clk) begin
        if (srst) begin
            extPrev_reg <= 4'h0;
        end else begin
            extPrev_reg <= extNow;
        end
    end

    // Sticky status; a new event wins over a simultaneous clear, so an edge
    // arriving while software clears the bit is never lost.
    always @(posedge clk) begin
        if (srst) begin
            irqStatus_reg <= 4'h0;
        end else begin
            if (wrStb && addr == `IOP_IRQ_CLEAR) begin
                irqStatus_reg <= (irqStatus_reg & ~wrData[3:0]) | extRise;
            end else begin
                irqStatus_reg <= irqStatus_reg | extRise;
            end
        end
    end
    assign irq = |(irqStatus_reg & irqEnable_reg);

    // Read decode; unmapped and write-only addresses return zero.
    // Addresses are compared in order, one register per address.
    always @* begin
        rdData_next = 8'h00;
        if (addr == `IOP_PA_DATA) begin
            rdData_next = paRead;
        end else if (addr == `IOP_PA_DIR) begin
            rdData_next = paDir_reg;
        end else if (addr == `IOP_PB_DATA) begin
            rdData_next = pbRead;
        end else if (addr == `IOP_PB_DIR) begin
            rdData_next = pbDir_reg;
        end else if (addr == `IOP_PC_DATA) begin
            rdData_next = {pcData_reg[7:3], pcRead};
        end else if (addr == `IOP_PC_DIR) begin
            rdData_next = pcDir_reg;
        end else if (addr == `IOP_IRQ_STATUS) begin
            rdData_next = {4'h0, irqStatus_reg};
        end else if (addr == `IOP_IRQ_ENABLE) begin
            rdData_next = {4'h0, irqEnable_reg};
        end else if (addr == `IOP_MISC) begin
            rdData_next = misc_reg | `IOP_MISC_RSVD;
        end else if (addr == `IOP_EXT_CFG) begin
            rdData_next = {4'h0, extCfg_reg};
        end
    end

    // Read data stand for one cycle after the strobe and are zero otherwise, so
    // a stale value can never be mistaken for a fresh answer.
    always @(posedge clk) begin
        if (srst) begin
            rdData <= 8'h00;
        end else if (rdStb) begin
            rdData <= rdData_next;
        end else begin
            rdData <= 8'h00;
        end
    end

    // Sticky misc bits handed to the detector and the oscillator.
    assign lowVoltageDetectDisable = misc_reg[`IOP_MISC_DETOFF];
    assign crystalRateSelect = misc_reg[`IOP_MISC_XTAL];
endmodule

// File: tb/iop_board.sv
// Board model for the nineteen port pins.
`timescale 1ns/1ns
module iop_board (
    input wire [18:0] pinOut,
    input wire [18:0] pinOe_n,
    input wire [18:0] boardLevel,
    output wire [18:0] pinIn
);
    // A pin the block drives shows that drive; an open-drain pin only ever pulls low.
    assign pinIn = (pinOe_n & boardLevel) | (~pinOe_n & pinOut);
endmodule

// File: tb/iop_ports_bench.sv
// Self-checking bench for the I/O port block.
`timescale 1ns/1ns
module iop_ports_bench;
    reg clk = 0, srst = 1, wrStb = 0, rdStb = 0, serEn = 0;
    reg [3:0] addr = 4'h0;
    reg [7:0] wrData = 8'h00, bB = 8'h5A;
    reg [2:0] chan = 3'h0;
    wire [7:0] rdData, aIn, aOut, aOe_n, bIn, bOut, bOe_n, anSel;
    wire [2:0] cIn, cOut, cOe_n;
    wire irq, sdaSeen, sclSeen, rxSeen;
    integer failCount = 0, numChecks = 0, i;
    // Free-running 20 MHz clock.
    always #25 clk = ~clk;
    iop_board u_board (.pinOut({aOut, bOut, cOut}), .pinOe_n({aOe_n, bOe_n, cOe_n}),
        .boardLevel({8'hA5, bB, 3'h5}), .pinIn({aIn, bIn, cIn}));
    iop_ports u_dut (.clk(clk), .srst(srst), .addr(addr), .wrData(wrData), .wrStb(wrStb),
        .rdStb(rdStb), .rdData(rdData), .portAIn(aIn), .portAOut(aOut), .portAOe_n(aOe_n),
        .portBIn(bIn), .portBOut(bOut), .portBOe_n(bOe_n), .portCIn(cIn), .portCOut(cOut),
        .portCOe_n(cOe_n), .i2cEnable(1'b1), .sdaOut(1'b0), .sclOut(1'b0),
        .sdaIn(sdaSeen), .sclIn(sclSeen),
        .serialEnable(serEn), .serialTx(1'b1), .serialRx(rxSeen), .usbTxActive(1'b1),
        .analogChannelSelect(chan), .analogInputSelect(anSel), .extIrqLines(),
        .lowVoltageDetectDisable(), .crystalRateSelect(), .irq(irq));
    task chk(input string n, input [7:0] e, input [7:0] g);
        begin
            numChecks = numChecks + 1;
            if (g !== e) begin
                failCount = failCount + 1;
                $display("CHECK FAILED %s expected %h seen %h", n, e, g);
            end
        end
    endtask
    // One bus cycle; a read compares the data that stands in the following cycle.
    task acc(input w, input [3:0] a, input [7:0] d);
        begin
            @(posedge clk);
            addr <= a;
            wrData <= d;
            wrStb <= w;
            rdStb <= !w;
            @(posedge clk);
            wrStb <= 1'b0;
            rdStb <= 1'b0;
            #1 if (!w) chk("rdData", d, rdData);
        end
    endtask
    task conclude;
        begin
            $display("checks %0d mismatches %0d", numChecks, failCount);
            if (failCount == 0 && numChecks > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    // Cut a hang short; the tests need fewer than a hundred cycles.
    initial begin
        #100000;
        failCount = failCount + 1;
        conclude;
    end
    // Reset, then the register, pin and interrupt sequences.
    initial begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        // Let the pin synchronisers fill before the first pin read.
        repeat (2) @(posedge clk);
        acc(0, 4'h0, 8'hA1);
        chk("pinsA", 8'h00, {6'h00, aOe_n[2:1]});
        chk("sdaIn", 8'h00, {7'h00, sdaSeen});
        chk("sclIn", 8'h00, {7'h00, sclSeen});
        acc(0, 4'h1, 8'h00);
        acc(0, 4'h5, 8'hF8);
        acc(0, 4'hF, 8'h00);
        acc(1, 4'h2, 8'h3C);
        acc(1, 4'h3, 8'h0F);
        acc(0, 4'h2, 8'h5C);
        acc(1, 4'h5, 8'hFF);
        acc(0, 4'h4, 8'hF8);
        @(posedge clk) serEn <= 1'b1;
        acc(1, 4'h9, 8'h0F);
        chk("pinsC", 8'h06, {5'h00, cOut & 3'h6});
        chk("serialRx", 8'h01, {7'h00, rxSeen});
        acc(1, 4'h9, 8'h00);
        acc(0, 4'h9, 8'hFC);
        for (i = 0; i < 8; i = i + 1) begin
            @(posedge clk) chan <= i[2:0];
            @(posedge clk) #1 chk("anSel", 8'h01 << i, anSel);
        end
        acc(1, 4'hA, 8'h0F);
        acc(1, 4'h8, 8'h0F);
        acc(0, 4'h6, 8'h05);
        chk("irq", 8'h01, {7'h00, irq});
        acc(1, 4'h7, 8'h05);
        @(posedge clk) bB <= 8'h7A;
        repeat (4) @(posedge clk);
        acc(0, 4'h6, 8'h02);
        acc(1, 4'h8, 8'h00);
        chk("irq", 8'h00, {7'h00, irq});
        acc(1, 4'h2, 8'hF0);
        acc(1, 4'h3, 8'hFF);
        acc(0, 4'h6, 8'h02);
        conclude;
    end
endmodule

// File: tb/iop_ports_sva.sv
// Checker for the I/O port block, with its bind.
`timescale 1ns/1ns
module iop_ports_sva (
    input wire clk,
    input wire srst,
    input wire [3:0] addr,
    input wire [7:0] wrData,
    input wire wrStb,
    input wire rdStb,
    input wire [7:0] rdData,
    input wire [7:0] portAOut,
    input wire [7:0] portBOe_n,
    input wire [3:0] extIrqLines,
    input wire lowVoltageDetectDisable,
    input wire crystalRateSelect
);
    // One clock domain, so the clock and the reset are given once.
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    wire miscWr = wrStb && addr == 4'h9;
    wire detOff = lowVoltageDetectDisable;
    wire xtal = crystalRateSelect;
    dir_drive_a: assert property (wrStb && addr == 4'h3 |=> portBOe_n == ~$past(wrData))
        else $error("direction write not seen on port B enables");
    pc_upper_a: assert property (rdStb && addr[3:1] == 3'h2 |=> rdData[7:3] == 5'h1F)
        else $error("port C upper bits not read as ones");
    misc_rsvd_a: assert property (rdStb && addr == 4'h9 |=> rdData[7:4] == 4'hF)
        else $error("misc reserved bits not read as ones");
    unmapped_zero_a: assert property (rdStb && addr > 4'hA |=> rdData == 8'h00)
        else $error("unmapped read not zero");
    detect_sticky_a: assert property (detOff || miscWr && wrData[3] |=> detOff)
        else $error("detector disable bit lost or not set");
    xtal_sticky_a: assert property (xtal || miscWr && wrData[2] |=> xtal)
        else $error("crystal rate bit lost or not set");
    clk_out_a: assert property (miscWr && wrData[0] |=> ##1 $changed(portAOut[0]))
        else $error("clock image not toggling on pin A0");
    out_no_irq_a: assert property ((~portBOe_n[7:4] & extIrqLines) == 4'h0)
        else $error("output pin raised an interrupt line");
endmodule

bind iop_ports iop_ports_sva u_sva (.clk(clk), .srst(srst), .addr(addr), .wrData(wrData),
    .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .portAOut(portAOut),
    .portBOe_n(portBOe_n), .extIrqLines(extIrqLines),
    .lowVoltageDetectDisable(lowVoltageDetectDisable), .crystalRateSelect(crystalRateSelect));
